// *** verilog/acs_map.vh ***
/*
 * Register map, field positions and reset values of the comparator status block.
 * Assumes it is included by bare name from the design files; holds definitions only.
 */
`ifndef ACS_MAP_VH
`define ACS_MAP_VH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define ACS_ADDR_W 12
`define ACS_OFF_CTRL0 12'h000
`define ACS_OFF_CTRL1 12'h004
`define ACS_OFF_STATUS 12'h008
`define ACS_OFF_EVENT 12'h00c
`define ACS_OFF_MASK 12'h010

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define ACS_CTRL_W 7
`define ACS_BIT_ON 0
`define ACS_BIT_IE 1
`define ACS_BIT_HYST 2
`define ACS_BIT_NEG 4
`define ACS_BIT_INV 6
`define ACS_CTRL_WMASK 7'h57
`define ACS_CTRL_RST 7'h00

// ----------------------------------------------------------------------------
// Status, event and mask register fields
// ----------------------------------------------------------------------------
`define ACS_NUM_CMP 2
`define ACS_ST_FLAG_LSB 0
`define ACS_ST_OUT_LSB 2
`define ACS_FLAG_RST 2'h0
`define ACS_EVT_RST 2'h0
`define ACS_MASK_RST 2'h0
`define ACS_SYNC_RST 1'b0
`define ACS_RDATA_RST 32'h0000_0000

`endif

// *** verilog/acs_sync2.v ***
/*
 * Two-stage level synchroniser for one asynchronous comparator output.
 * Assumes the input is a slow analog level; the output is safe to read in the clock domain.
 */
`timescale 1ns/1ps
`include "acs_map.vh"

module acs_sync2 (
    // Clock, reset and enable
    input wire clk_i,
    input wire rst_n_i,
    input wire ce_i,
    // Level in and out
    input wire d_i,
    output wire q_o
);

    reg meta_reg;
    reg sync_reg;

    // ------------------------------------------------------------------------
    // Synchroniser chain
    // ------------------------------------------------------------------------
    // The first stage feeds only the second stage.
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_reg <= `ACS_SYNC_RST;
            sync_reg <= `ACS_SYNC_RST;
        end else if (ce_i) begin
            meta_reg <= d_i;
            sync_reg <= meta_reg;
        end
    end

    assign q_o = sync_reg;

endmodule

// *** verilog/acs_status.v ***
/*
 * Status and interrupt logic for two analog comparators, reached over APB.
 * Holds both control registers, the status register, an event register and its mask.
 * Assumes the comparator outputs are asynchronous levels and the APB master runs on CLK_SYS_I.
 */
`timescale 1ns/1ps
`include "acs_map.vh"

module acs_status (
    // Clock, reset and enable
    input wire CLK_SYS_I,
    input wire RESETN_I,
    input wire CE_I,
    // APB slave
    input wire PSEL_I,
    input wire PENABLE_I,
    input wire PWRITE_I,
    input wire [`ACS_ADDR_W-1:0] PADDR_I,
    input wire [31:0] PWDATA_I,
    input wire [3:0] PSTRB_I,
    output wire [31:0] PRDATA_O,
    output wire PREADY_O,
    output wire PSLVERR_O,
    // Raw comparator outputs
    input wire [`ACS_NUM_CMP-1:0] CMP_RAW_I,
    // Controls towards the analog comparators
    output wire [`ACS_NUM_CMP-1:0] CMP_ON_O,
    output wire [`ACS_NUM_CMP-1:0] HYST_EN_O,
    output wire [`ACS_NUM_CMP-1:0] NEG_SEL_O,
    // Interrupts
    output wire CMP_IRQ_O,
    output wire EVT_IRQ_O
);

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    reg [`ACS_CTRL_W-1:0] ctrl0_reg;
    reg [`ACS_CTRL_W-1:0] ctrl0_next;
    reg [`ACS_CTRL_W-1:0] ctrl1_reg;
    reg [`ACS_CTRL_W-1:0] ctrl1_next;
    reg [`ACS_NUM_CMP-1:0] prev_reg;
    reg [`ACS_NUM_CMP-1:0] flag_reg;
    reg [`ACS_NUM_CMP-1:0] flag_next;
    reg [`ACS_NUM_CMP-1:0] evt_reg;
    reg [`ACS_NUM_CMP-1:0] evt_next;
    reg [`ACS_NUM_CMP-1:0] mask_reg;
    reg [`ACS_NUM_CMP-1:0] mask_next;
    reg [31:0] rdata_reg;
    reg [31:0] rdata_next;
    reg cmp_irq_reg;
    reg evt_irq_reg;
    reg [31:0] rd_mux;

    wire [`ACS_NUM_CMP-1:0] cmp_sync;
    wire [`ACS_NUM_CMP-1:0] cmp_on;
    wire [`ACS_NUM_CMP-1:0] cmp_ie;
    wire [`ACS_NUM_CMP-1:0] cmp_inv;
    wire [`ACS_NUM_CMP-1:0] cmp_level;
    wire [`ACS_NUM_CMP-1:0] cmp_out;
    wire [`ACS_NUM_CMP-1:0] cmp_change;
    wire [`ACS_NUM_CMP-1:0] ie_next;
    wire [`ACS_NUM_CMP-1:0] flag_w1c;
    wire [`ACS_NUM_CMP-1:0] evt_rclr;
    wire apb_setup;
    wire apb_access;
    wire apb_wr;
    wire apb_rd;
    wire sel_ctrl0;
    wire sel_ctrl1;
    wire sel_status;
    wire sel_event;
    wire sel_mask;
    wire addr_mapped;
    wire [31:0] status_word;

    // ------------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < `ACS_NUM_CMP; i = i + 1) begin : g_sync
            acs_sync2 u_sync (
                .clk_i(CLK_SYS_I),
                .rst_n_i(RESETN_I),
                .ce_i(CE_I),
                .d_i(CMP_RAW_I[i]),
                .q_o(cmp_sync[i])
            );
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------------------
    assign cmp_on = {ctrl1_reg[`ACS_BIT_ON], ctrl0_reg[`ACS_BIT_ON]};
    assign cmp_ie = {ctrl1_reg[`ACS_BIT_IE], ctrl0_reg[`ACS_BIT_IE]};
    assign cmp_inv = {ctrl1_reg[`ACS_BIT_INV], ctrl0_reg[`ACS_BIT_INV]};
    assign ie_next = {ctrl1_next[`ACS_BIT_IE], ctrl0_next[`ACS_BIT_IE]};

    assign CMP_ON_O = cmp_on;
    assign HYST_EN_O = {ctrl1_reg[`ACS_BIT_HYST], ctrl0_reg[`ACS_BIT_HYST]};
    assign NEG_SEL_O = {ctrl1_reg[`ACS_BIT_NEG], ctrl0_reg[`ACS_BIT_NEG]};

    // ------------------------------------------------------------------------
    // Output conditioning and change detection
    // ------------------------------------------------------------------------
    assign cmp_level = cmp_sync ^ cmp_inv;
    assign cmp_out = cmp_level & cmp_on;
    // A disabled comparator raises no change; enabling one whose level is high
    // raises no change either, because the previous level is still tracked while off.
    assign cmp_change = cmp_on & (cmp_level ^ prev_reg);

    // ------------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------------
    assign apb_setup = PSEL_I & ~PENABLE_I;
    assign apb_access = PSEL_I & PENABLE_I & CE_I;
    assign sel_ctrl0 = (PADDR_I == `ACS_OFF_CTRL0);
    assign sel_ctrl1 = (PADDR_I == `ACS_OFF_CTRL1);
    assign sel_status = (PADDR_I == `ACS_OFF_STATUS);
    assign sel_event = (PADDR_I == `ACS_OFF_EVENT);
    assign sel_mask = (PADDR_I == `ACS_OFF_MASK);
    assign addr_mapped = sel_ctrl0 | sel_ctrl1 | sel_status | sel_event | sel_mask;
    assign apb_wr = apb_access & PWRITE_I & addr_mapped & PSTRB_I[0];
    assign apb_rd = apb_access & ~PWRITE_I & addr_mapped;

    // The access phase always completes in one cycle unless the block is frozen.
    assign PREADY_O = CE_I;
    assign PSLVERR_O = PSEL_I & PENABLE_I & ~addr_mapped;
    assign PRDATA_O = rdata_reg;

    // ------------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------------
    assign status_word = {28'h000_0000, cmp_out, flag_reg};

    always @* begin
        rd_mux = `ACS_RDATA_RST;
        if (sel_ctrl0) begin
            rd_mux = {25'h000_0000, ctrl0_reg};
        end else if (sel_ctrl1) begin
            rd_mux = {25'h000_0000, ctrl1_reg};
        end else if (sel_status) begin
            rd_mux = status_word;
        end else if (sel_event) begin
            rd_mux = {30'h0000_0000, evt_reg};
        end else if (sel_mask) begin
            rd_mux = {30'h0000_0000, mask_reg};
        end
    end

    // Read data is captured in the setup cycle so it is registered at the access edge.
    always @* begin
        rdata_next = rdata_reg;
        if (apb_setup & ~PWRITE_I) begin
            rdata_next = rd_mux;
        end
    end

    // ------------------------------------------------------------------------
    // Control and mask writes
    // ------------------------------------------------------------------------
    always @* begin
        ctrl0_next = ctrl0_reg;
        ctrl1_next = ctrl1_reg;
        mask_next = mask_reg;
        if (apb_wr & sel_ctrl0) begin
            ctrl0_next = PWDATA_I[`ACS_CTRL_W-1:0] & `ACS_CTRL_WMASK;
        end
        if (apb_wr & sel_ctrl1) begin
            ctrl1_next = PWDATA_I[`ACS_CTRL_W-1:0] & `ACS_CTRL_WMASK;
        end
        if (apb_wr & sel_mask) begin
            mask_next = PWDATA_I[`ACS_NUM_CMP-1:0];
        end
    end

    // ------------------------------------------------------------------------
    // Change flags and events
    // ------------------------------------------------------------------------
    assign flag_w1c = (apb_wr & sel_status) ? PWDATA_I[`ACS_ST_FLAG_LSB+`ACS_NUM_CMP-1:`ACS_ST_FLAG_LSB] :
                      `ACS_FLAG_RST;
    // Only the event bits that the read actually returned are cleared.
    assign evt_rclr = (apb_rd & sel_event) ? rdata_reg[`ACS_NUM_CMP-1:0] : `ACS_EVT_RST;

    always @* begin
        flag_next = cmp_change | (flag_reg & ~flag_w1c);
        evt_next = cmp_change | (evt_reg & ~evt_rclr);
    end

    // ------------------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------------------
    always @(posedge CLK_SYS_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            ctrl0_reg <= `ACS_CTRL_RST;
            ctrl1_reg <= `ACS_CTRL_RST;
            prev_reg <= `ACS_FLAG_RST;
            flag_reg <= `ACS_FLAG_RST;
            evt_reg <= `ACS_EVT_RST;
            mask_reg <= `ACS_MASK_RST;
            rdata_reg <= `ACS_RDATA_RST;
            cmp_irq_reg <= 1'b0;
            evt_irq_reg <= 1'b0;
        end else if (CE_I) begin
            ctrl0_reg <= ctrl0_next;
            ctrl1_reg <= ctrl1_next;
            prev_reg <= cmp_level;
            flag_reg <= flag_next;
            evt_reg <= evt_next;
            mask_reg <= mask_next;
            rdata_reg <= rdata_next;
            cmp_irq_reg <= |(flag_next & ie_next);
            evt_irq_reg <= |(evt_next & mask_next);
        end
    end

    // ------------------------------------------------------------------------
    // Interrupt outputs
    // ------------------------------------------------------------------------
    assign CMP_IRQ_O = cmp_irq_reg;
    assign EVT_IRQ_O = evt_irq_reg;

endmodule

// *** bench/acs_status_sva.sv ***
/*
 * Port-level assertions for the comparator status block.
 * Assumes one clock domain and attachment to acs_status by the bind below.
 */
`timescale 1ns/1ps
`include "acs_map.vh"
module acs_status_sva (
    // Clock, reset and enable
    input wire CLK_SYS_I,
    input wire RESETN_I,
    input wire CE_I,
    // APB slave
    input wire PSEL_I,
    input wire PENABLE_I,
    input wire PWRITE_I,
    input wire [`ACS_ADDR_W-1:0] PADDR_I,
    input wire [31:0] PWDATA_I,
    input wire [3:0] PSTRB_I,
    input wire [31:0] PRDATA_O,
    // Comparator side
    input wire [`ACS_NUM_CMP-1:0] CMP_RAW_I,
    input wire [`ACS_NUM_CMP-1:0] CMP_ON_O,
    input wire CMP_IRQ_O
);
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!RESETN_I);
    wire acc = PSEL_I && PENABLE_I && CE_I;
    wire wr = acc && PWRITE_I && PSTRB_I[0];
    wire rd_st = acc && !PWRITE_I && PADDR_I == `ACS_OFF_STATUS;
    reg [1:0] raw_reg;
    reg [3:0] quiet_reg;
    // Counts cycles since the last raw change or register write.
    always @(posedge CLK_SYS_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            raw_reg <= 2'h0;
            quiet_reg <= 4'h0;
        end else begin
            raw_reg <= CMP_RAW_I;
            if (CMP_RAW_I != raw_reg || wr)
                quiet_reg <= 4'h0;
            else if (CE_I && quiet_reg != 4'hf)
                quiet_reg <= quiet_reg + 4'h1;
        end
    end
    AST_IRQ_CAUSE: assert property ($rose(CMP_IRQ_O) |-> quiet_reg < 4'h6)
        else $error("comparator irq rose without a cause");
    AST_IRQ_CLEAR: assert property ($fell(CMP_IRQ_O) |-> $past(wr))
        else $error("comparator irq fell without a write");
    AST_IRQ_QUIET: assert property (quiet_reg > 4'h6 && !wr |=> $stable(CMP_IRQ_O))
        else $error("comparator irq moved while idle");
    AST_ON0: assert property (wr && PADDR_I == `ACS_OFF_CTRL0 |=> CMP_ON_O[0] == $past(PWDATA_I[0]))
        else $error("cmp0 enable not written");
    AST_ON1: assert property (wr && PADDR_I == `ACS_OFF_CTRL1 |=> CMP_ON_O[1] == $past(PWDATA_I[0]))
        else $error("cmp1 enable not written");
    AST_ON_HOLD: assert property (!wr |=> $stable(CMP_ON_O))
        else $error("enable changed without a write");
    AST_OFF_ZERO: assert property (rd_st && $past(CMP_ON_O) == 2'h0 |-> PRDATA_O[3:2] == 2'h0)
        else $error("disabled comparator output read as one");
    AST_RSVD: assert property (rd_st |-> PRDATA_O[31:4] == 28'h0)
        else $error("status upper bits not zero");
    cover property ($rose(CMP_IRQ_O));
    cover property ($fell(CMP_IRQ_O));
    cover property (rd_st && PRDATA_O[1:0] != 2'h0);
endmodule

bind acs_status acs_status_sva u_acs_status_sva (.CLK_SYS_I(CLK_SYS_I), .RESETN_I(RESETN_I),
    .CE_I(CE_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
    .PWDATA_I(PWDATA_I), .PSTRB_I(PSTRB_I), .PRDATA_O(PRDATA_O), .CMP_RAW_I(CMP_RAW_I),
    .CMP_ON_O(CMP_ON_O), .CMP_IRQ_O(CMP_IRQ_O));

// *** bench/acs_cmp_model.sv ***
/*
 * Behavioural pair of analog comparator outputs.
 * Assumes the bench sets target levels; outputs settle after a short or a long delay.
 */
`timescale 1ns/1ps
module acs_cmp_model (
    // Target levels and settling choice
    input wire [1:0] level_i,
    input wire slow_i,
    // Comparator outputs, unrelated to the bus clock
    output logic [1:0] out_o
);
    initial out_o = 2'h0;
    always @(level_i) out_o <= #(slow_i ? 37 : 3) level_i;
endmodule

// *** bench/acs_status_test.sv ***
/*
 * Self-checking bench for the comparator status block.
 * Assumes acs_status, the comparator model and the checker are compiled before it.
 */
`timescale 1ns/1ps
`include "acs_map.vh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin miscompares++; \
    $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module acs_status_test;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [1:0] level = 2'h0;
    logic slow = 1'b0;
    logic [31:0] exp_rd;
    logic [31:0] exq[$];
    logic [1:0] old;
    logic [1:0] nw;
    wire [31:0] prdata;
    wire pready;
    wire [1:0] raw;
    wire cmp_irq;
    wire evt_irq;
    wire pslverr;
    wire [1:0] hyst;
    wire [1:0] neg;
    int miscompares = 0;
    int cmp_count = 0;
    int cycles = 0;
    acs_cmp_model u_acs_cmp_model (.level_i(level), .slow_i(slow), .out_o(raw));
    acs_status u_acs_status (.CLK_SYS_I(clk), .RESETN_I(rst_n), .CE_I(1'b1), .PSEL_I(psel),
        .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(4'hf),
        .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .CMP_RAW_I(raw), .CMP_ON_O(),
        .HYST_EN_O(hyst), .NEG_SEL_O(neg), .CMP_IRQ_O(cmp_irq), .EVT_IRQ_O(evt_irq));
    always #10 clk = ~clk;
    task results;
        $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            results;
        end
    end
    // Read data is taken at the edge that completes the access.
    always @(posedge clk) begin
        if (psel && pen && !pwr && pready) begin
            exp_rd = exq.pop_front();
            `CHK(prdata, exp_rd)
            `CHK(pslverr, (paddr > `ACS_OFF_MASK))
        end
    end
    // For a read, d is the expected data.
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        if (!w) exq.push_back(d);
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (!pready) @(posedge clk);
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    initial begin
        void'($urandom(32'h609f));
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        apb(0, `ACS_OFF_STATUS, 32'h0);
        apb(1, `ACS_OFF_CTRL0, 32'hffff_fffe);
        apb(0, `ACS_OFF_CTRL0, 32'h56);
        @(negedge clk);
        `CHK({hyst, neg}, 4'h5)
        apb(0, 12'h014, 32'h0);
        apb(1, `ACS_OFF_CTRL0, 32'h0);
        apb(1, `ACS_OFF_CTRL0, 32'h3);
        apb(1, `ACS_OFF_CTRL1, 32'h3);
        apb(1, `ACS_OFF_MASK, 32'h3);
        old = 2'h0;
        for (int i = 0; i < 8; i++) begin
            nw = 2'($urandom);
            slow <= 1'($urandom);
            level <= nw;
            repeat (8) @(posedge clk);
            `CHK(cmp_irq, |(nw ^ old))
            `CHK(evt_irq, |(nw ^ old))
            apb(0, `ACS_OFF_EVENT, {30'h0, nw ^ old});
            apb(0, `ACS_OFF_STATUS, {28'h0, nw, nw ^ old});
            apb(1, `ACS_OFF_STATUS, 32'h3);
            old = nw;
        end
        level <= 2'h1;
        repeat (8) @(posedge clk);
        apb(1, `ACS_OFF_STATUS, 32'h3);
        apb(1, `ACS_OFF_CTRL1, 32'h41);
        repeat (4) @(posedge clk);
        apb(1, `ACS_OFF_STATUS, 32'h0);
        apb(0, `ACS_OFF_STATUS, 32'he);
        @(negedge clk);
        `CHK(cmp_irq, 1'b0)
        level <= 2'h2;
        repeat (8) @(posedge clk);
        apb(0, `ACS_OFF_STATUS, 32'h3);
        @(negedge clk);
        `CHK(cmp_irq, 1'b1)
        apb(1, `ACS_OFF_CTRL0, 32'h0);
        apb(1, `ACS_OFF_CTRL1, 32'h0);
        level <= 2'h3;
        repeat (8) @(posedge clk);
        apb(0, `ACS_OFF_STATUS, 32'h3);
        apb(1, `ACS_OFF_STATUS, 32'h3);
        apb(0, `ACS_OFF_STATUS, 32'h0);
        @(negedge clk);
        `CHK(cmp_irq, 1'b0)
        results;
    end
endmodule
